// ==== core/pbssp_burst_ctr.sv ====
// Two-bit burst offset counter, interleaved or linear order
`timescale 1ns/1ns
module pbssp_burst_ctr (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       load,
  input  wire logic [1:0] load_val,
  input  wire logic       step,
  input  wire logic       linear,
  // Offset out
  output logic      [1:0] ofs
);

  logic [1:0] start_r;
  logic [1:0] start_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       lin_r;
  logic       lin_nxt;

  // Order is taken at load so a mode change never scrambles a running burst
  always_comb begin
    start_nxt = start_r;
    cnt_nxt   = cnt_r;
    lin_nxt   = lin_r;
    if (load) begin
      start_nxt = load_val;
      cnt_nxt   = pbssp_pkg::OFS_RST;
      lin_nxt   = linear;
    // RQ3 step on advance
    end else if (step) begin
      cnt_nxt = cnt_r + pbssp_pkg::OFS_STEP;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_r <= pbssp_pkg::OFS_RST;
      cnt_r   <= pbssp_pkg::OFS_RST;
      lin_r   <= 1'b0;
    end else begin
      start_r <= start_nxt;
      cnt_r   <= cnt_nxt;
      lin_r   <= lin_nxt;
    end
  end

  // RQ4 interleave or linear
  // RQ13 wraps in four
  always_comb begin
    if (lin_r) begin
      ofs = start_r + cnt_r;
    end else begin
      ofs = start_r ^ cnt_r;
    end
  end

  a_interleave_step: assert property (@(posedge sys_clk) disable iff (rst) // RQ4
    (step && !load && !lin_r && !cnt_r[0]) |=> (ofs == ($past(ofs) ^ 2'h1)))
    else $error("interleaved step from even count did not flip bit 0");

endmodule // pbssp_burst_ctr

// ==== core/pbssp_pkg.sv ====
// Constants, carrier types and summary for the pipelined burst SRAM port
// Summary of operation
// RQ1: Every synchronous input is captured in input registers on the rising clock edge.
// RQ2: Address and chip selects load only in a cycle where either address strobe is active.
// RQ3: Later burst addresses come from a two-bit counter that steps only on burst advance.
// RQ4: The counter follows either an interleaved or a linear order, chosen by the user.
// RQ5: Writes register address, data and controls and then complete without a write pulse.
// RQ6: Per-lane write selects update only the chosen bytes, so one, two or four may change.
// RQ7: Global write low writes every byte lane regardless of the lane selects.
// RQ8: Output enable and sleep act without waiting for a clock edge.
// RQ9: A deselect takes effect after a single clock cycle, not through the whole pipeline.
// RQ10: A four-beat burst gives first data after three cycles and one beat per cycle after.
// RQ11: Read data leaves through an output register updated on the clock edge.
// RQ12: The array is built as 2M words of 36 bits or 4M words of 18 bits.
// RQ13: The counter changes only the two low address bits and wraps within an aligned group.
package pbssp_pkg;

  localparam int DATA_W_WIDE   = 36;
  localparam int DATA_W_NARROW = 18;
  localparam int ADDR_W_WIDE   = 21;
  localparam int ADDR_W_NARROW = 22;
  localparam int LANE_W        = 9;
  localparam int BURST_W       = 2;
  localparam int SYNC_STAGES   = 3;
  localparam int READ_LATENCY  = 3;

  localparam logic [1:0] OFS_RST  = 2'h0;
  localparam logic [1:0] OFS_STEP = 2'h1;

  // Synchronous control pins, sampled together on each edge
  typedef struct packed {
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_advance_n;
    logic pipelined_chip_select_n;
    logic depth_select_high;
    logic depth_select_low_n;
    logic byte_write_enable_n;
    logic global_write_all_n;
  } pbssp_ctrl_type;

endpackage

// ==== core/pbssp_port.sv ====
// Pipelined burst synchronous SRAM port with array, burst counter and output stage
`timescale 1ns/1ns
module pbssp_port #(
  parameter bit WIDE   = 1'b1,
  parameter int DATA_W = WIDE ? pbssp_pkg::DATA_W_WIDE : pbssp_pkg::DATA_W_NARROW,
  parameter int ADDR_W = WIDE ? pbssp_pkg::ADDR_W_WIDE : pbssp_pkg::ADDR_W_NARROW,
  parameter int LANES  = DATA_W / pbssp_pkg::LANE_W
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // Synchronous bus
  input  wire pbssp_pkg::pbssp_ctrl_type  ctrl,
  input  wire logic [ADDR_W-1:0]          addr,
  input  wire logic [LANES-1:0]           byte_lane_write_select_n,
  input  wire logic [DATA_W-1:0]          dq_in,
  // Asynchronous pins
  input  wire logic                       output_enable_n,
  input  wire logic                       sleep_request,
  input  wire logic                       burst_linear,
  // Data pins
  output logic      [DATA_W-1:0]          dq_out,
  output logic                            dq_oe_n
);

  localparam int WORDS = 2 ** ADDR_W;

  // RQ12 array organisation
  logic [DATA_W-1:0] mem [WORDS];

  // Sleep and order pins are not tied to the clock, so they are synchronised
  logic [pbssp_pkg::SYNC_STAGES-1:0] slp_sync_r;
  logic [pbssp_pkg::SYNC_STAGES-1:0] lin_sync_r;
  logic                              sleep_q_r;
  logic                              sleep_q_nxt;
  logic                              linear_q_r;
  logic                              linear_q_nxt;

  always_comb begin
    sleep_q_nxt  = sleep_q_r;
    linear_q_nxt = linear_q_r;
    if (slp_sync_r[1] == slp_sync_r[2]) begin
      sleep_q_nxt = slp_sync_r[2];
    end
    if (lin_sync_r[1] == lin_sync_r[2]) begin
      linear_q_nxt = lin_sync_r[2];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slp_sync_r <= '0;
      lin_sync_r <= '0;
      sleep_q_r  <= 1'b0;
      linear_q_r <= 1'b0;
    end else begin
      slp_sync_r <= {slp_sync_r[1:0], sleep_request};
      lin_sync_r <= {lin_sync_r[1:0], burst_linear};
      sleep_q_r  <= sleep_q_nxt;
      linear_q_r <= linear_q_nxt;
    end
  end

  // Input stage
  logic              act_r;
  logic              act_nxt;
  logic              wr_r;
  logic              wr_nxt;
  logic [LANES-1:0]  lanes_r;
  logic [LANES-1:0]  lanes_nxt;
  logic [DATA_W-1:0] din_r;
  logic [ADDR_W-1:0] base_r;
  logic [ADDR_W-1:0] base_nxt;
  logic              chip_sel;
  logic              proc_start;
  logic              ctrl_start;
  logic              new_start;
  logic              desel_now;
  logic              wr_req;
  logic [LANES-1:0]  lanes_req;
  logic              step;
  logic [1:0]        ofs;
  logic [ADDR_W-1:0] cur_addr;

  always_comb begin
    chip_sel   = !ctrl.pipelined_chip_select_n && ctrl.depth_select_high
                 && !ctrl.depth_select_low_n;
    // Processor strobe is ignored while the pipelined select is inactive
    proc_start = !ctrl.processor_address_strobe_n && !ctrl.pipelined_chip_select_n;
    ctrl_start = !ctrl.controller_address_strobe_n;
    new_start  = (proc_start || ctrl_start) && !sleep_q_r;
    desel_now  = new_start && !chip_sel;
    // RQ7 global write wins
    // RQ6 lane writes
    if (!ctrl.global_write_all_n) begin
      lanes_req = '1;
    end else if (!ctrl.byte_write_enable_n) begin
      lanes_req = ~byte_lane_write_select_n;
    end else begin
      lanes_req = '0;
    end
    wr_req = |lanes_req;
    step   = !new_start && act_r && !ctrl.burst_advance_n;
  end

  always_comb begin
    act_nxt   = act_r;
    wr_nxt    = 1'b0;
    lanes_nxt = '0;
    base_nxt  = base_r;
    if (sleep_q_r) begin
      act_nxt = 1'b0;
    // RQ2 strobe gated load
    end else if (new_start) begin
      act_nxt  = chip_sel;
      base_nxt = addr;
      // A processor strobe start is always a read; writes follow later
      if (chip_sel && !proc_start) begin
        wr_nxt    = wr_req;
        lanes_nxt = lanes_req;
      end
    end else if (act_r) begin
      wr_nxt    = wr_req;
      lanes_nxt = lanes_req;
    end
  end

  // RQ1 input registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      act_r   <= 1'b0;
      wr_r    <= 1'b0;
      lanes_r <= '0;
      din_r   <= '0;
      base_r  <= '0;
    end else begin
      act_r   <= act_nxt;
      wr_r    <= wr_nxt;
      lanes_r <= lanes_nxt;
      din_r   <= dq_in;
      base_r  <= base_nxt;
    end
  end

  // RQ3 internal burst count
  pbssp_burst_ctr pbssp_burst_ctr_inst (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .load     (new_start),
    .load_val (addr[1:0]),
    .step     (step),
    .linear   (linear_q_r),
    .ofs      (ofs)
  );

  // RQ13 high bits held
  assign cur_addr = {base_r[ADDR_W-1:2], ofs};

  // Array stage
  logic              rd_valid_r;
  logic              rd_valid_nxt;
  logic [DATA_W-1:0] rd_data_r;

  always_comb begin
    rd_valid_nxt = act_r && !wr_r && !desel_now;
  end

  // RQ5 self-timed write
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (act_r && wr_r && lanes_r[i]) begin
        mem[cur_addr][i*pbssp_pkg::LANE_W +: pbssp_pkg::LANE_W] <=
          din_r[i*pbssp_pkg::LANE_W +: pbssp_pkg::LANE_W];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
    end else begin
      rd_valid_r <= rd_valid_nxt;
      if (act_r && !wr_r) begin
        rd_data_r <= mem[cur_addr];
      end
    end
  end

  // Output stage
  logic              out_en_r;
  logic              out_en_nxt;
  logic [DATA_W-1:0] dq_out_r;
  logic [DATA_W-1:0] dq_out_nxt;

  always_comb begin
    // RQ9 single cycle deselect
    out_en_nxt = rd_valid_r && !desel_now && !sleep_q_r;
    dq_out_nxt = rd_valid_r ? rd_data_r : dq_out_r;
  end

  // RQ11 output register
  // RQ10 three cycle first beat
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_en_r <= 1'b0;
      dq_out_r <= '0;
    end else begin
      out_en_r <= out_en_nxt;
      dq_out_r <= dq_out_nxt;
    end
  end

  assign dq_out = dq_out_r;
  // RQ8 asynchronous enables
  // Only gating path off the register; the pins must act without an edge
  assign dq_oe_n = !(out_en_r && !output_enable_n && !sleep_request);

  a_strobe_load: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
    (new_start && chip_sel) |=> (base_r == $past(addr)))
    else $error("address not loaded on strobe");

  a_no_strobe_hold: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
    (!new_start) |=> (base_r == $past(base_r)))
    else $error("address changed without strobe");

  a_linear_step: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
    (step && linear_q_r && !sleep_q_r) |=> (ofs == $past(ofs) + 2'h1))
    else $error("linear burst did not advance by one");

  a_hold_no_adv: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
    (!new_start && !step) |=> (ofs == $past(ofs)))
    else $error("burst offset moved without advance");

  a_global_all: assert property (@(posedge sys_clk) disable iff (rst) // RQ7
    (act_r && !new_start && !sleep_q_r && !ctrl.global_write_all_n)
      |=> (wr_r && lanes_r == '1))
    else $error("global write did not select all lanes");

  a_lane_select: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
    (act_r && !new_start && !sleep_q_r && ctrl.global_write_all_n
      && !ctrl.byte_write_enable_n) |=> (lanes_r == ~$past(byte_lane_write_select_n)))
    else $error("lane write mask wrong");

  a_read_latency: assert property (@(posedge sys_clk) disable iff (rst) // RQ10
    (new_start && chip_sel && proc_start) ##1 (!desel_now && !sleep_q_r)
      ##1 (!desel_now && !sleep_q_r) |=> out_en_r)
    else $error("first read beat not on third edge");

  a_out_reg: assert property (@(posedge sys_clk) disable iff (rst) // RQ11
    (rd_valid_r && !desel_now && !sleep_q_r) |=> (out_en_r && dq_out == $past(rd_data_r)))
    else $error("output register did not take read data");

  a_desel_fast: assert property (@(posedge sys_clk) disable iff (rst) // RQ9
    desel_now |=> (!out_en_r && dq_oe_n))
    else $error("deselect not seen after one cycle");

  a_sleep_off: assert property (@(posedge sys_clk) disable iff (rst) // RQ8
    (sleep_request || output_enable_n) |-> dq_oe_n)
    else $error("data driven while sleep or output enable off");

endmodule // pbssp_port

// ==== tb/pbssp_bus_master.sv ====
// Bus master model driving the port's synchronous pins
`timescale 1ns/1ns
module pbssp_bus_master (
  // Clock
  input  wire logic                 sys_clk,
  // Synchronous pins
  output pbssp_pkg::pbssp_ctrl_type ctrl,
  output logic [5:0]                addr,
  output logic [3:0]                lane_sel_n,
  output logic [35:0]               dq_in
);
  initial begin
    ctrl = 8'hEB;
    addr = 6'h00;
    lane_sel_n = 4'hF;
    dq_in = 36'h0;
  end
  task automatic bus(input pbssp_pkg::pbssp_ctrl_type c, input logic [5:0] a,
                     input logic [3:0] ls, input logic [35:0] d, input bit dv);
    @(posedge sys_clk);
    ctrl <= c;
    addr <= a;
    lane_sel_n <= ls;
    // Idle data toggles so a stale word never passes for a fresh one
    dq_in <= dv ? d : ~dq_in;
  endtask
endmodule // pbssp_bus_master

// ==== tb/test_pipelined_burst_sync_sram_port.sv ====
// Self-checking bench for the pipelined burst SRAM port
`timescale 1ns/1ns
module test_pipelined_burst_sync_sram_port;
  localparam pbssp_pkg::pbssp_ctrl_type IDL = 8'hEB;
  localparam pbssp_pkg::pbssp_ctrl_type BURST_ADVANCE = 8'hCB;
  localparam pbssp_pkg::pbssp_ctrl_type RDP = 8'h6B;
  localparam pbssp_pkg::pbssp_ctrl_type RDC = 8'hAB;
  localparam pbssp_pkg::pbssp_ctrl_type WRG = 8'hA8;
  localparam pbssp_pkg::pbssp_ctrl_type WRB = 8'hA9;
  localparam pbssp_pkg::pbssp_ctrl_type DSL = 8'hBB;
  localparam pbssp_pkg::pbssp_ctrl_type WAG = 8'hCA;
  localparam pbssp_pkg::pbssp_ctrl_type WAB = 8'hC9;
  logic                      sys_clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      output_enable_n = 1'b0;
  logic                      sleep_request = 1'b0;
  logic                      burst_linear = 1'b0;
  pbssp_pkg::pbssp_ctrl_type ctrl;
  logic [5:0]                addr;
  logic [3:0]                lane_sel_n;
  logic [35:0]               dq_in;
  logic [35:0]               dq_out;
  logic                      dq_oe_n;
  logic [35:0]               mem [64];
  int                        errors = 0;
  int                        n_checks = 0;
  int                        cyc_cnt = 0;

  pbssp_port #(.WIDE(1'b1), .ADDR_W(6)) pbssp_port_inst (
    .sys_clk(sys_clk), .rst(rst), .ctrl(ctrl), .addr(addr),
    .byte_lane_write_select_n(lane_sel_n), .dq_in(dq_in),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .burst_linear(burst_linear), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
  pbssp_bus_master pbssp_bus_master_inst (
    .sys_clk(sys_clk), .ctrl(ctrl), .addr(addr), .lane_sel_n(lane_sel_n), .dq_in(dq_in));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // Run is about 120 cycles, so this only trips on a hang
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 1000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk_d(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input pbssp_pkg::pbssp_ctrl_type c, input logic [5:0] a,
                     input logic [3:0] ls, input logic [35:0] d);
    pbssp_bus_master_inst.bus(c, a, ls, d, !c.global_write_all_n || !c.byte_write_enable_n);
    #1;
  endtask
  // Reference copy follows lane selects unless global write is low
  task automatic wr(input pbssp_pkg::pbssp_ctrl_type c, input logic [5:0] a,
                    input logic [3:0] ls, input logic [35:0] d);
    cyc(c, a, ls, d);
    for (int i = 0; i < 4; i++)
      if (!c.global_write_all_n || !ls[i]) mem[a][9*i+:9] = d[9*i+:9];
  endtask
  task automatic rd_by(input pbssp_pkg::pbssp_ctrl_type c, input logic [5:0] a);
    cyc(c, a, 4'hF, '0);
    repeat (4) cyc(IDL, a, 4'hF, '0);
    chk_d(dq_out, mem[a]);
  endtask
  task automatic rd(input logic [5:0] a);
    rd_by(RDP, a);
  endtask
  task automatic t_burst(input logic lin, input logic [5:0] base);
    logic [1:0] o;
    @(posedge sys_clk);
    burst_linear <= lin;
    repeat (6) cyc(IDL, base, 4'hF, '0);
    for (int k = 0; k < 8; k++) begin
      cyc(k == 0 ? RDP : (k < 4 ? BURST_ADVANCE : IDL), base, 4'hF, '0);
      // Last pass is a suspended burst, which repeats the final beat
      o = 2'(k > 6 ? 3 : k - pbssp_pkg::READ_LATENCY);
      o = lin ? base[1:0] + o : base[1:0] ^ o;
      if (k >= pbssp_pkg::READ_LATENCY) begin
        chk_d(dq_out, mem[{base[5:2], o}]);
        chk_b(dq_oe_n, 1'b0);
      end
    end
    cyc(DSL, base, 4'hF, '0);
    chk_b(dq_oe_n, 1'b0);
    cyc(IDL, base, 4'hF, '0);
    chk_b(dq_oe_n, 1'b1);
    $display("test burst done");
  endtask
  task automatic t_lanes();
    wr(WRB, 6'h24, 4'b1010, 36'hF_FFFF_FFFF);
    wr(WRB, 6'h24, 4'b0111, 36'h0_0000_0000);
    wr(WRG, 6'h25, 4'b1110, 36'h9_8765_4321);
    rd(6'h24);
    rd(6'h25);
    $display("test lanes done");
  endtask
  // Linear order is still selected: beats go 25, 26, 27 and wrap to 24
  task automatic t_wburst();
    wr(WRG, 6'h25, 4'hF, 36'h1_1111_1111);
    wr(WAB, 6'h26, 4'h6, 36'h2_2222_2222);
    wr(WAG, 6'h27, 4'hE, 36'h3_3333_3333);
    wr(WAB, 6'h24, 4'hC, 36'h4_4444_4444);
    rd_by(RDC, 6'h25);
    rd(6'h26);
    rd(6'h27);
    rd(6'h24);
    $display("test write burst done");
  endtask
  task automatic t_async();
    @(posedge sys_clk);
    output_enable_n <= 1'b1;
    #1 chk_b(dq_oe_n, 1'b1);
    @(posedge sys_clk);
    output_enable_n <= 1'b0;
    sleep_request <= 1'b1;
    #1 chk_b(dq_oe_n, 1'b1);
    repeat (6) cyc(IDL, 6'h26, 4'hF, '0);
    // Write while asleep must be dropped, so the reference copy is untouched
    cyc(WRG, 6'h26, 4'hF, 36'h0);
    @(posedge sys_clk);
    sleep_request <= 1'b0;
    repeat (6) cyc(IDL, 6'h26, 4'hF, '0);
    rd(6'h26);
    $display("test async done");
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 36; a < 40; a++)
      wr(WRG, 6'(a), 4'hF, {30'h2345678, 6'(a)});
    t_burst(1'b0, 6'h25);
    t_burst(1'b1, 6'h26);
    t_lanes();
    t_wburst();
    t_async();
    report_and_stop();
  end
endmodule // test_pipelined_burst_sync_sram_port
